/* hw/aipx_crossbar.sv */
// Input capture and six-channel crossbar with register port and exponent pins.
// Assumes port clocks and pins are asynchronous to clk_i; register master on clk_i.
`timescale 1ns/100ps
`default_nettype none
`include "aipx_defines.svh"
// Operation
// - Four independent ports, up to 150 MSPS, each sampled on its own clock.
// - Any port may feed any of six channels, chosen per channel.
// - Each channel has a 3-bit source select field in input control.
// - Pseudo-noise test generator is an extra selectable source.
// - One sample stream per port; no time-interleaved demultiplexing.
// - Each port captures on rising or falling clock edge by configuration.
// - Port A clock is the reference for the processing clock multiplier.
// - Sample is 16-bit mantissa plus 3-bit exponent, or fixed point.
// - Mantissa is two's complement, exponent unsigned.
// - Exponent pins may be gain-range outputs, direction set by configuration.
// - Clock-invert bit in clock control picks each port's capture edge.
// - Complex mode pairs A with B and C with D, each enabled separately.
// - Per-channel complex bit plus first-port select gives paired stream.
module aipx_crossbar (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic port_a_sample_clock_i,
	input wire logic port_b_sample_clock_i,
	input wire logic port_c_sample_clock_i,
	input wire logic port_d_sample_clock_i,
	input wire aipx_pkg::aipx_mant_t port_a_mantissa_i,
	input wire aipx_pkg::aipx_mant_t port_b_mantissa_i,
	input wire aipx_pkg::aipx_mant_t port_c_mantissa_i,
	input wire aipx_pkg::aipx_mant_t port_d_mantissa_i,
	input wire aipx_pkg::aipx_exp_t pair_ab_exponent_i,
	output aipx_pkg::aipx_exp_t pair_ab_exponent_o,
	output logic pair_ab_exponent_oe_n_o,
	input wire aipx_pkg::aipx_exp_t port_b_exponent_i,
	output aipx_pkg::aipx_exp_t port_b_exponent_o,
	output logic port_b_exponent_oe_n_o,
	input wire aipx_pkg::aipx_exp_t pair_cd_exponent_i,
	output aipx_pkg::aipx_exp_t pair_cd_exponent_o,
	output logic pair_cd_exponent_oe_n_o,
	input wire aipx_pkg::aipx_exp_t port_d_exponent_i,
	output aipx_pkg::aipx_exp_t port_d_exponent_o,
	output logic port_d_exponent_oe_n_o,
	output logic pll_ref_clk_o,
	output logic [5:0][15:0] ch_i_o,
	output logic [5:0][15:0] ch_q_o,
	output logic [5:0] ch_cplx_o,
	output logic [5:0] ch_valid_o
);
	import aipx_pkg::*;

	// ==========================================================
	// Helpers
	// Signed mantissa, unsigned shift
	function automatic aipx_mant_t aipx_scale(input aipx_mant_t m, input aipx_exp_t e);
		aipx_scale = $signed(m) >>> e;
	endfunction : aipx_scale

	function automatic aipx_src_t aipx_ch_sel(input logic [25:0] ctl, input int n);
		aipx_ch_sel = aipx_src_t'(ctl[n*`AIPX_SEL_W +: `AIPX_SEL_W]);
	endfunction : aipx_ch_sel

	// ==========================================================
	// Registers
	logic [25:0] inctl_r, inctl_nxt;
	logic [3:0] clkctl_r, clkctl_nxt;
	logic [15:0] gain_r, gain_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [3:0] exp_dir;
	logic pair_ab, pair_cd;
	logic [3:0][15:0] cap_mant;
	logic [3:0][2:0] cap_exp;
	logic [3:0] cap_stb;
	logic [3:0] cap_lvl;
	aipx_mant_t pn;

	always_comb begin
		inctl_nxt = inctl_r;
		clkctl_nxt = clkctl_r;
		gain_nxt = gain_r;
		if (reg_wr_i) begin
			if (reg_addr_i == `AIPX_REG_INCTL) begin
				inctl_nxt = reg_wdata_i[`AIPX_INCTL_W-1:0];
			end else if (reg_addr_i == `AIPX_REG_CLKCTL) begin
				clkctl_nxt = reg_wdata_i[`AIPX_CLKCTL_W-1:0];
			end else if (reg_addr_i == `AIPX_REG_GAIN) begin
				gain_nxt = reg_wdata_i[`AIPX_GAIN_W-1:0];
			end
		end
	end

	always_comb begin
		rdata_nxt = 32'h00000000;
		// Zero outside the answer cycle, so a stale word never looks fresh
		if (reg_rd_i) begin
			if (reg_addr_i == `AIPX_REG_INCTL) begin
				rdata_nxt = {6'h00, inctl_r};
			end else if (reg_addr_i == `AIPX_REG_CLKCTL) begin
				rdata_nxt = {28'h0000000, clkctl_r};
			end else if (reg_addr_i == `AIPX_REG_GAIN) begin
				rdata_nxt = {16'h0000, gain_r};
			end else if (reg_addr_i == `AIPX_REG_SAMPLE_A) begin
				rdata_nxt = {13'h0000, cap_exp[0], cap_mant[0]};
			end else if (reg_addr_i == `AIPX_REG_SAMPLE_B) begin
				rdata_nxt = {13'h0000, cap_exp[1], cap_mant[1]};
			end else if (reg_addr_i == `AIPX_REG_SAMPLE_C) begin
				rdata_nxt = {13'h0000, cap_exp[2], cap_mant[2]};
			end else if (reg_addr_i == `AIPX_REG_SAMPLE_D) begin
				rdata_nxt = {13'h0000, cap_exp[3], cap_mant[3]};
			end else if (reg_addr_i == `AIPX_REG_PN) begin
				rdata_nxt = {16'h0000, pn};
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			inctl_r <= `AIPX_INCTL_RST;
			clkctl_r <= `AIPX_CLKCTL_RST;
			gain_r <= `AIPX_GAIN_RST;
			rdata_r <= 32'h00000000;
		end else begin
			inctl_r <= inctl_nxt;
			clkctl_r <= clkctl_nxt;
			gain_r <= gain_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign reg_rdata_o = rdata_r;
	assign exp_dir = gain_r[`AIPX_EXPDIR_LSB +: 4];
	assign pair_ab = inctl_r[`AIPX_PAIR_AB_BIT];
	assign pair_cd = inctl_r[`AIPX_PAIR_CD_BIT];

	// ==========================================================
	// Ports
	logic [3:0] pclk;
	logic [3:0][15:0] pmant;
	logic [3:0][2:0] pexp;
	assign pclk = {port_d_sample_clock_i, port_c_sample_clock_i,
		port_b_sample_clock_i, port_a_sample_clock_i};
	assign pmant = {port_d_mantissa_i, port_c_mantissa_i,
		port_b_mantissa_i, port_a_mantissa_i};
	assign pexp = {port_d_exponent_i, pair_cd_exponent_i,
		port_b_exponent_i, pair_ab_exponent_i};

	for (genvar p = 0; p < 4; p++) begin : g_port
		aipx_port_capture u_cap (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.sample_clk_i(pclk[p]),
			.mant_i(pmant[p]),
			.exp_i(pexp[p]),
			.edge_inv_i(clkctl_r[`AIPX_INV_LSB + p]),
			.exp_out_mode_i(exp_dir[p]),
			.mant_o(cap_mant[p]),
			.exp_o(cap_exp[p]),
			.stb_o(cap_stb[p]),
			.clk_lvl_o(cap_lvl[p])
		);
	end

	aipx_pn_gen u_pn (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pn_o(pn)
	);

	assign pll_ref_clk_o = cap_lvl[0];

	// ==========================================================
	// Exponent pins
	// Gain range outputs
	assign pair_ab_exponent_o = gain_r[`AIPX_GAIN_LSB +: 3];
	assign port_b_exponent_o = gain_r[`AIPX_GAIN_LSB + 3 +: 3];
	assign pair_cd_exponent_o = gain_r[`AIPX_GAIN_LSB + 6 +: 3];
	assign port_d_exponent_o = gain_r[`AIPX_GAIN_LSB + 9 +: 3];
	assign pair_ab_exponent_oe_n_o = ~exp_dir[0];
	assign port_b_exponent_oe_n_o = ~(exp_dir[1] & ~pair_ab);
	assign pair_cd_exponent_oe_n_o = ~exp_dir[2];
	assign port_d_exponent_oe_n_o = ~(exp_dir[3] & ~pair_cd);

	// ==========================================================
	// Crossbar
	logic [5:0][15:0] ch_i_r, ch_i_nxt, ch_q_r, ch_q_nxt;
	logic [5:0] cplx_r, cplx_nxt, vld_r, vld_nxt;

	always_comb begin
		aipx_src_t sel;
		logic [1:0] p;
		logic cx_ok;
		sel = AIPX_SRC_A;
		p = 2'h0;
		cx_ok = 1'b0;
		ch_i_nxt = ch_i_r;
		ch_q_nxt = ch_q_r;
		cplx_nxt = cplx_r;
		vld_nxt = 6'h00;
		for (int n = 0; n < 6; n++) begin
			sel = aipx_ch_sel(inctl_r, n);
			p = sel[1:0];
			// Complex only from A or C
			cx_ok = inctl_r[`AIPX_CPLX_LSB + n] &&
				((sel == AIPX_SRC_A && pair_ab) || (sel == AIPX_SRC_C && pair_cd));
			if (sel == AIPX_SRC_PN) begin
				vld_nxt[n] = 1'b1;
				ch_i_nxt[n] = pn;
				ch_q_nxt[n] = 16'h0000;
				cplx_nxt[n] = 1'b0;
			end else if (sel <= AIPX_SRC_D && cap_stb[p]) begin
				// One word per strobe, no demux
				vld_nxt[n] = 1'b1;
				ch_i_nxt[n] = aipx_scale(cap_mant[p], cap_exp[p]);
				ch_q_nxt[n] = cx_ok ? aipx_scale(cap_mant[2'(p + 2'h1)],
					cap_exp[2'(p + 2'h1)]) : 16'h0000;
				cplx_nxt[n] = cx_ok;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ch_i_r <= '0;
			ch_q_r <= '0;
			cplx_r <= 6'h00;
			vld_r <= 6'h00;
		end else begin
			ch_i_r <= ch_i_nxt;
			ch_q_r <= ch_q_nxt;
			cplx_r <= cplx_nxt;
			vld_r <= vld_nxt;
		end
	end
	assign ch_i_o = ch_i_r;
	assign ch_q_o = ch_q_r;
	assign ch_cplx_o = cplx_r;
	assign ch_valid_o = vld_r;

	// ==========================================================
	// Checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	route_port_a: assert property ((aipx_ch_sel(inctl_r, 0) == AIPX_SRC_A)
		&& cap_stb[0]
		|=> vld_r[0] && ch_i_r[0] == aipx_scale($past(cap_mant[0]), $past(cap_exp[0])))
		else $error("channel 0 missed port A sample");
	route_port_d_a: assert property ((aipx_ch_sel(inctl_r, 5) == AIPX_SRC_D)
		&& !cap_stb[3] |=> !vld_r[5])
		else $error("channel 5 valid without port D strobe");
	reserved_code_a: assert property (inctl_r[2:0] > 3'h4 |=> !vld_r[0])
		else $error("reserved source produced data");
	pn_route_a: assert property ((aipx_ch_sel(inctl_r, 1) == AIPX_SRC_PN)
		|=> vld_r[1] && ch_i_r[1] == $past(pn))
		else $error("test source not routed");
	pn_real_a: assert property ((aipx_ch_sel(inctl_r, 5) == AIPX_SRC_PN)
		|=> vld_r[5] && !cplx_r[5] && ch_q_r[5] == 16'h0000)
		else $error("test source not delivered as real data");
	cplx_pair_a: assert property ((aipx_ch_sel(inctl_r, 0) == AIPX_SRC_C) && pair_cd
		&& inctl_r[`AIPX_CPLX_LSB] && cap_stb[2] |=> cplx_r[0]
		&& ch_q_r[0] == aipx_scale($past(cap_mant[3]), $past(cap_exp[3])))
		else $error("complex pair C/D not delivered");
	cplx_refuse_a: assert property (vld_r[2] && cplx_r[2]
		|-> $past(inctl_r[`AIPX_PAIR_AB_BIT] | inctl_r[`AIPX_PAIR_CD_BIT]))
		else $error("complex output without pair enable");
	exp_drive_a: assert property (!port_b_exponent_oe_n_o |-> !pair_ab && exp_dir[1])
		else $error("port B exponent driven while paired or input");
	pair_exp_a: assert property (pair_cd |-> port_d_exponent_oe_n_o)
		else $error("port D exponent driven while paired");
	inctl_write_a: assert property (reg_wr_i && reg_addr_i == `AIPX_REG_INCTL
		|=> inctl_r == $past(reg_wdata_i[25:0]))
		else $error("input control write lost");
	read_unmapped_a: assert property (reg_rd_i && reg_addr_i == 8'h0C
		|=> reg_rdata_o == 32'h00000000)
		else $error("unmapped read not zero");
	read_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h00000000)
		else $error("read data outside its answer cycle");
	read_pn_a: assert property (reg_rd_i && reg_addr_i == `AIPX_REG_PN
		|=> reg_rdata_o == {16'h0000, $past(pn)})
		else $error("test word read back wrong");

	cover_pn_c: cover property (vld_r[0] && inctl_r[2:0] == 3'h4);
	cover_cplx_c: cover property (vld_r[0] && cplx_r[0]);
	cover_all_c: cover property (vld_r == 6'h3F);
endmodule : aipx_crossbar
`default_nettype wire

/* hw/aipx_defines.svh */
// Offsets, field positions, reset values and limits of the input port crossbar.
// Assumes a 32-bit register port with byte addresses and one word per register.
`ifndef AIPX_DEFINES_SVH
`define AIPX_DEFINES_SVH

// ==========================================================
// Register offsets
`define AIPX_REG_INCTL 8'h00
`define AIPX_REG_CLKCTL 8'h04
`define AIPX_REG_GAIN 8'h08
`define AIPX_REG_SAMPLE_A 8'h10
`define AIPX_REG_SAMPLE_B 8'h14
`define AIPX_REG_SAMPLE_C 8'h18
`define AIPX_REG_SAMPLE_D 8'h1C
`define AIPX_REG_PN 8'h20

// ==========================================================
// Field positions
`define AIPX_SEL_W 3
`define AIPX_CPLX_LSB 18
`define AIPX_PAIR_AB_BIT 24
`define AIPX_PAIR_CD_BIT 25
`define AIPX_INCTL_W 26
`define AIPX_INV_LSB 0
`define AIPX_CLKCTL_W 4
`define AIPX_EXPDIR_LSB 0
`define AIPX_GAIN_LSB 4
`define AIPX_GAIN_W 16

// ==========================================================
// Reset values and limits
`define AIPX_INCTL_RST 26'h0000000
`define AIPX_CLKCTL_RST 4'h0
`define AIPX_GAIN_RST 16'h0000
`define AIPX_PN_SEED 16'hACE1
`define AIPX_PORT_MAX_MSPS 150

`endif

/* hw/aipx_pkg.sv */
// Types shared by the input port crossbar files.
// Assumes the constants header is included where offsets are needed.
package aipx_pkg;
	typedef logic [15:0] aipx_mant_t;
	typedef logic [2:0] aipx_exp_t;
	// Crossbar source codes; 5 to 7 are reserved
	typedef enum logic [2:0] {
		AIPX_SRC_A = 3'h0,
		AIPX_SRC_B = 3'h1,
		AIPX_SRC_C = 3'h2,
		AIPX_SRC_D = 3'h3,
		AIPX_SRC_PN = 3'h4
	} aipx_src_t;
endpackage : aipx_pkg

/* hw/aipx_port_capture.sv */
// One sample port: synchronises the port clock and pins, captures on the chosen edge.
// Assumes the port clock runs well below half of clk_i.
`timescale 1ns/100ps
`default_nettype none
module aipx_port_capture (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sample_clk_i,
	input wire aipx_pkg::aipx_mant_t mant_i,
	input wire aipx_pkg::aipx_exp_t exp_i,
	input wire logic edge_inv_i,
	input wire logic exp_out_mode_i,
	output aipx_pkg::aipx_mant_t mant_o,
	output aipx_pkg::aipx_exp_t exp_o,
	output logic stb_o,
	output logic clk_lvl_o
);
	import aipx_pkg::*;
	logic clk_s1_r, clk_s2_r, clk_s3_r;
	logic [2:0] fill_r;
	logic [18:0] dat_s1_r, dat_s2_r, dat_s3_r;
	aipx_mant_t mant_r, mant_nxt;
	aipx_exp_t exp_r, exp_nxt;
	logic stb_r, stb_nxt, edge_seen;

	// ==========================================================
	// Synchronisers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			clk_s1_r <= 1'b0;
			clk_s2_r <= 1'b0;
			clk_s3_r <= 1'b0;
			fill_r <= 3'h0;
			dat_s1_r <= 19'h00000;
			dat_s2_r <= 19'h00000;
			dat_s3_r <= 19'h00000;
		end else begin
			clk_s1_r <= sample_clk_i;
			clk_s2_r <= clk_s1_r;
			clk_s3_r <= clk_s2_r;
			fill_r <= {fill_r[1:0], 1'b1};
			dat_s1_r <= {exp_i, mant_i};
			dat_s2_r <= dat_s1_r;
			dat_s3_r <= dat_s2_r;
		end
	end

	// ==========================================================
	// Capture
	// Edge choice per port
	// Stages hold reset zeros at first; a high pin would look like an edge
	assign edge_seen = fill_r[2] & (edge_inv_i ? (clk_s3_r & ~clk_s2_r) : (~clk_s3_r & clk_s2_r));
	always_comb begin
		mant_nxt = mant_r;
		exp_nxt = exp_r;
		stb_nxt = 1'b0;
		if (edge_seen) begin
			// Word from before the edge: the pins may already move after it
			// Held in clk_i registers, not on the port clock
			mant_nxt = dat_s3_r[15:0];
			exp_nxt = exp_out_mode_i ? 3'h0 : dat_s3_r[18:16];
			stb_nxt = 1'b1;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mant_r <= 16'h0000;
			exp_r <= 3'h0;
			stb_r <= 1'b0;
		end else begin
			mant_r <= mant_nxt;
			exp_r <= exp_nxt;
			stb_r <= stb_nxt;
		end
	end
	assign mant_o = mant_r;
	assign exp_o = exp_r;
	assign stb_o = stb_r;
	assign clk_lvl_o = clk_s2_r;

	// ==========================================================
	// Checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	edge_polarity_a: assert property (stb_r |-> (clk_s3_r == ~$past(edge_inv_i)))
		else $error("capture on wrong clock edge");
	single_strobe_a: assert property (stb_r |=> !stb_r)
		else $error("capture strobe longer than one cycle");
	cover_fall_c: cover property (edge_inv_i && stb_r);
endmodule : aipx_port_capture
`default_nettype wire

/* hw/aipx_pn_gen.sv */
// Pseudo-noise test source for the crossbar, one new word each clock.
// Assumes nothing beyond clk_i and rst_i.
`timescale 1ns/100ps
`default_nettype none
`include "aipx_defines.svh"
module aipx_pn_gen (
	input wire logic clk_i,
	input wire logic rst_i,
	output aipx_pkg::aipx_mant_t pn_o
);
	import aipx_pkg::*;
	aipx_mant_t lfsr_r, lfsr_nxt;

	// ==========================================================
	// Sequence
	// Test word generator
	always_comb begin
		lfsr_nxt = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lfsr_r <= `AIPX_PN_SEED;
		end else begin
			lfsr_r <= lfsr_nxt;
		end
	end
	assign pn_o = lfsr_r;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	pn_running_a: assert property (lfsr_r != 16'h0000)
		else $error("test sequence locked at zero");
endmodule : aipx_pn_gen
`default_nettype wire

/* bench/aipx_adc_model.sv */
// Four converter ports: sample clocks and words, words change away from the capture edge.
// Assumes the bench resolves the shared exponent pins from the device output enables.
`timescale 1ns/100ps
`default_nettype none
module aipx_adc_model (
	input wire logic run_i,
	input wire logic [3:0] inv_i,
	input wire logic [3:0] exp_drv_i,
	input wire logic fixed_i,
	output logic [3:0] clk_o,
	output logic [3:0][15:0] mant_o,
	output wire logic [3:0][2:0] exp_o
);
	// ==========================================================
	// Port clocks and words
	for (genvar p = 0; p < 4; p++) begin : g_port
		logic [2:0] e_r;
		assign exp_o[p] = exp_drv_i[p] ? e_r : ~e_r;
		initial begin
			clk_o[p] = 1'b0;
			mant_o[p] = 16'h0000;
			e_r = 3'h0;
			// Odd offsets keep the ports unrelated in phase
			#(3.3 + 29.1 * p);
			forever begin
				#80;
				if (run_i) begin
					clk_o[p] = ~clk_o[p];
					if (clk_o[p] == inv_i[p]) begin
						mant_o[p] = 16'($urandom);
						e_r = fixed_i ? 3'h0 : 3'($urandom_range(7, 0));
					end
				end
			end
		end
	end
endmodule : aipx_adc_model
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench of the input port crossbar against a queue-based model.
// Assumes aipx_adc_model on the ports and the design sources under hw/.
`timescale 1ns/100ps
`default_nettype none
`include "aipx_defines.svh"
`define TB_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	import aipx_pkg::*;
	logic clk_i;
	logic rst_i = 1'b1;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic [3:0] pclk;
	logic [3:0][15:0] pmant;
	wire logic [3:0][2:0] pexp_m;
	logic [3:0][2:0] exp_o;
	logic [3:0][2:0] exp_w;
	logic [3:0] oe_n;
	logic pll_ref;
	logic [5:0][15:0] ch_i;
	logic [5:0][15:0] ch_q;
	logic [5:0] ch_cplx;
	logic [5:0] ch_valid;
	logic run = 1'b0;
	logic fixed = 1'b0;
	logic [31:0] inctl = 32'h0;
	logic [31:0] clkctl = 32'h0;
	logic [31:0] gain = 32'h0;
	logic [15:0] prev;
	logic [15:0] pn_m;
	logic [15:0] pn_d;
	logic [31:0] ic;
	bit mon_on = 1'b0;
	int mismatches = 0;
	int checks_done = 0;
	int cap_cnt[4];
	int val_cnt[6];
	int ref_cnt;
	logic [18:0] hq[4][$];

	aipx_crossbar aipx_crossbar_i (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.port_a_sample_clock_i(pclk[0]), .port_b_sample_clock_i(pclk[1]),
		.port_c_sample_clock_i(pclk[2]), .port_d_sample_clock_i(pclk[3]),
		.port_a_mantissa_i(pmant[0]), .port_b_mantissa_i(pmant[1]),
		.port_c_mantissa_i(pmant[2]), .port_d_mantissa_i(pmant[3]),
		.pair_ab_exponent_i(exp_w[0]), .pair_ab_exponent_o(exp_o[0]),
		.pair_ab_exponent_oe_n_o(oe_n[0]), .port_b_exponent_i(exp_w[1]),
		.port_b_exponent_o(exp_o[1]), .port_b_exponent_oe_n_o(oe_n[1]),
		.pair_cd_exponent_i(exp_w[2]), .pair_cd_exponent_o(exp_o[2]),
		.pair_cd_exponent_oe_n_o(oe_n[2]), .port_d_exponent_i(exp_w[3]),
		.port_d_exponent_o(exp_o[3]), .port_d_exponent_oe_n_o(oe_n[3]),
		.pll_ref_clk_o(pll_ref), .ch_i_o(ch_i), .ch_q_o(ch_q), .ch_cplx_o(ch_cplx),
		.ch_valid_o(ch_valid));
	aipx_adc_model aipx_adc_model_i (.run_i(run), .inv_i(clkctl[3:0]), .exp_drv_i(oe_n),
		.fixed_i(fixed), .clk_o(pclk), .mant_o(pmant), .exp_o(pexp_m));

	// ==========================================================
	// Clock, pins and reference model
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			exp_w[p] = (oe_n[p] === 1'b0) ? exp_o[p] : pexp_m[p];
		end
	end
	always @(posedge pll_ref) ref_cnt++;
	for (genvar p = 0; p < 4; p++) begin : g_cap
		always @(pclk[p]) begin
			if (pclk[p] === ~clkctl[p]) begin
				hq[p].push_back({(gain[p] ? 3'h0 : exp_w[p]), pmant[p]});
				if (hq[p].size() > 2) void'(hq[p].pop_front());
				cap_cnt[p]++;
			end
		end
	end
	function automatic logic [15:0] scaled(input logic [18:0] w);
		logic signed [15:0] m;
		m = w[15:0];
		return m >>> w[18:16];
	endfunction : scaled
	// Reference test sequence from the same seed; pn_d is what the channels carry
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pn_m <= `AIPX_PN_SEED;
			pn_d <= `AIPX_PN_SEED;
		end else begin
			pn_m <= {pn_m[14:0], pn_m[15] ^ pn_m[13] ^ pn_m[12] ^ pn_m[10]};
			pn_d <= pn_m;
		end
	end
	// Mid-cycle look, well clear of the edge that launches the outputs
	always @(negedge clk_i) begin
		if (mon_on) begin
			for (int n = 0; n < 6; n++) begin
				int s;
				bit c;
				s = inctl[3*n +: 3];
				c = inctl[18+n] && ((s == 0 && inctl[24]) || (s == 2 && inctl[25]));
				if (ch_valid[n] === 1'b1) begin
					val_cnt[n]++;
					`TB_CHK(s < 5, 1'b1)
					if (s < 4) begin
						`TB_CHK(ch_i[n], scaled(hq[s][$]))
						`TB_CHK(ch_cplx[n], c)
						if (c) begin
							`TB_CHK((ch_q[n] === scaled(hq[s+1][$])) ||
								(ch_q[n] === scaled(hq[s+1][0])), 1'b1)
						end else begin
							`TB_CHK(ch_q[n], 16'h0000)
						end
					end else if (s == 4) begin
						`TB_CHK(ch_i[n], pn_d)
						`TB_CHK(ch_q[n], 16'h0000)
						`TB_CHK(ch_cplx[n], 1'b0)
					end
				end
			end
		end
	end

	// ==========================================================
	// Register port and phase tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_i);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_i);
		reg_rd <= 1'b0;
		#1;
		`TB_CHK(reg_rdata, e)
	endtask : rd_chk
	task automatic cfg(input logic [31:0] i, input logic [31:0] c, input logic [31:0] g);
		mon_on = 1'b0;
		inctl = i & 32'h03FFFFFF;
		clkctl = c;
		gain = g;
		wr(`AIPX_REG_INCTL, i);
		wr(`AIPX_REG_CLKCTL, c);
		wr(`AIPX_REG_GAIN, g);
		// Let old captures drain out of the pipeline and queues
		repeat (40) @(posedge clk_i);
		#1;
		cap_cnt = '{default: 0};
		val_cnt = '{default: 0};
		ref_cnt = 0;
		mon_on = 1'b1;
	endtask : cfg
	task automatic count_chk(input int periods);
		int s;
		repeat (periods * 8) @(posedge clk_i);
		for (int n = 0; n < 6; n++) begin
			s = inctl[3*n +: 3];
			if (s < 4) `TB_CHK((val_cnt[n] - cap_cnt[s]) inside {[-1:1]}, 1'b1)
		end
		`TB_CHK((ref_cnt - cap_cnt[0]) inside {[-1:1]}, 1'b1)
	endtask : count_chk
	task automatic finish_test;
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (100000) @(posedge clk_i);
		mismatches++;
		finish_test();
	end

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'hcc4c));
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		run = 1'b1;
		#1;
		`TB_CHK(oe_n, 4'hF)
		rd_chk(`AIPX_REG_INCTL, 32'h0);
		rd_chk(`AIPX_REG_CLKCTL, 32'h0);
		rd_chk(`AIPX_REG_GAIN, 32'h0);
		ic = $urandom;
		wr(`AIPX_REG_INCTL, ic);
		rd_chk(`AIPX_REG_INCTL, ic & 32'h03FFFFFF);
		wr(`AIPX_REG_CLKCTL, 32'hFFFFFFFF);
		rd_chk(`AIPX_REG_CLKCTL, 32'hF);
		wr(8'h3C, ic);
		rd_chk(8'h3C, 32'h0);
		wr(`AIPX_REG_INCTL, 32'h0);
		wr(`AIPX_REG_GAIN, 32'h3D5F);
		#1;
		`TB_CHK(oe_n, 4'h0)
		`TB_CHK(exp_o, {3'h1, 3'h7, 3'h2, 3'h5})
		wr(`AIPX_REG_INCTL, 32'h03000000);
		#1;
		`TB_CHK(oe_n, 4'hA)
		// Random routing, edges and exponent directions
		for (int r = 0; r < 4; r++) begin
			fixed = r[0];
			ic = 32'h0;
			for (int n = 0; n < 6; n++) ic[3*n +: 3] = 3'($urandom_range(3, 0));
			cfg(ic, $urandom_range(15, 0), $urandom_range(15, 0));
			count_chk(12);
		end
		fixed = 1'b0;
		cfg(32'h032DA210, 32'h5, 32'h0);
		count_chk(10);
		// Test source on 0 and 5, reserved codes on 1 to 3
		cfg(32'h00020FAC, 32'h0, 32'h0);
		@(posedge clk_i);
		#1;
		prev = ch_i[0];
		for (int k = 0; k < 8; k++) begin
			@(posedge clk_i);
			#1;
			`TB_CHK(ch_valid[0], 1'b1)
			`TB_CHK(ch_i[0] !== prev, 1'b1)
			prev = ch_i[0];
		end
		count_chk(4);
		`TB_CHK(val_cnt[1] + val_cnt[2] + val_cnt[3], 0)
		// Test word register: answer holds the word of the strobe cycle
		@(posedge clk_i);
		reg_addr <= `AIPX_REG_PN;
		reg_rd <= 1'b1;
		@(posedge clk_i);
		reg_rd <= 1'b0;
		#1;
		`TB_CHK(reg_rdata, {16'h0000, pn_d})
		mon_on = 1'b0;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		inctl = 32'h0;
		// Nothing may come out before a real port edge has crossed
		repeat (4) begin
			@(posedge clk_i);
			#1;
			`TB_CHK(ch_valid, 6'h00)
		end
		rd_chk(`AIPX_REG_INCTL, 32'h0);
		finish_test();
	end
endmodule : tb
`default_nettype wire
